// ### upstream_tc_window_map_tb.sv
`timescale 1ns/1ps
module upstream_tc_window_map_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg global_upstream_class_permit = 1'b0;
  reg [7:0] reg_addr = 8'h0;
  reg [31:0] reg_wdata = 32'h0;
  wire [31:0] reg_rdata, up_addr;
  wire up_valid, up_is_mem, up_tc_valid, up_hit;
  wire [2:0] up_tc;
  integer n_fail = 0;
  integer checks_done = 0;
  integer i;
  always #12.5 clk = ~clk;
  utwm_master m (
    .clk(clk),
    .up_valid(up_valid),
    .up_is_mem(up_is_mem),
    .up_addr(up_addr)
  );
  utwm_window_map uut (
    .clk(clk),
    .rst(rst),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .global_upstream_class_permit(global_upstream_class_permit),
    .up_valid(up_valid),
    .up_is_mem(up_is_mem),
    .up_addr(up_addr),
    .up_tc_valid(up_tc_valid),
    .up_tc(up_tc),
    .up_hit(up_hit)
  );
  task chk(input [31:0] s, input [31:0] e);
    checks_done = checks_done + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task acc(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) chk(reg_rdata, d);
  endtask
  task cls(input [31:0] a, input m_is, input [4:0] e);
    m.issue(a, m_is);
    #1 chk({27'h0, up_tc_valid, up_tc, up_hit}, {27'h0, e});
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    global_upstream_class_permit <= 1'b1;
    for (i = 0; i < 6; i = i + 1) acc(0, 8'h14 + 8'h4 * i[7:0], 32'h0);
    acc(1, 8'h14, 32'hFFFFFFFF);
    acc(0, 8'h14, 32'hF);
    acc(1, 8'h14, 32'hE);
    acc(1, 8'h18, 32'h1000);
    acc(0, 8'h18, 32'h1000);
    acc(1, 8'h1C, 32'h1FFF);
    acc(0, 8'h1C, 32'h1FFF);
    acc(1, 8'h24, 32'hFFFFFFFF);
    acc(0, 8'h24, 32'hFFFFFFFF);
    acc(0, 8'h30, 32'h0);
    cls(32'h1000, 1, 5'h10);
    $display("test registers done");
    acc(1, 8'h14, 32'hB);
    cls(32'h1000, 1, 5'h1B);
    cls(32'h1FFF, 1, 5'h1B);
    cls(32'h2000, 1, 5'h10);
    acc(1, 8'h24, 32'h1800);
    acc(1, 8'h28, 32'h2FFF);
    acc(1, 8'h20, 32'h7);
    acc(0, 8'h20, 32'h7);
    acc(0, 8'h28, 32'h2FFF);
    cls(32'h1800, 1, 5'h1B);
    cls(32'h2FFF, 1, 5'h17);
    cls(32'h3000, 1, 5'h10);
    cls(32'h2000, 0, 5'h10);
    @(posedge clk) global_upstream_class_permit <= 1'b0;
    cls(32'h2000, 1, 5'h11);
    $display("test classify done");
    end_of_test;
  end
endmodule

// ### utwm_chk.sv
`timescale 1ns/1ps
module utwm_chk (
  input wire clk,
  input wire rst,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_rdata,
  input wire global_upstream_class_permit,
  input wire up_valid,
  input wire up_is_mem,
  input wire up_tc_valid,
  input wire [2:0] up_tc,
  input wire up_hit
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_answer_late: assert property (up_valid |=> up_tc_valid) else $error("late");
  a_answer_cause: assert property (up_tc_valid |-> $past(up_valid)) else $error("spurious");
  a_permit_zero: assert property (up_valid && !global_upstream_class_permit |=> up_tc == 3'h0)
    else $error("permit");
  a_nonmem_zero: assert property (up_valid && !up_is_mem |=> !up_hit && up_tc == 3'h0) else $error("nonmem");
  a_miss_zero: assert property (up_tc_valid && !up_hit |-> up_tc == 3'h0) else $error("miss");
  a_ctrl_rsvd: assert property (reg_rd && (reg_addr == 8'h14 || reg_addr == 8'h20) |=> reg_rdata[31:4] == 28'h0)
    else $error("reserved");
  a_class_hold: assert property (!up_valid |=> $stable(up_tc) && $stable(up_hit)) else $error("hold");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata");
endmodule
bind utwm_window_map utwm_chk chk_i (
  .clk(clk),
  .rst(rst),
  .reg_rd(reg_rd),
  .reg_addr(reg_addr),
  .reg_rdata(reg_rdata),
  .global_upstream_class_permit(global_upstream_class_permit),
  .up_valid(up_valid),
  .up_is_mem(up_is_mem),
  .up_tc_valid(up_tc_valid),
  .up_tc(up_tc),
  .up_hit(up_hit)
);

// ### utwm_defines.vh
`ifndef UTWM_DEFINES_VH
`define UTWM_DEFINES_VH

// ==========================================================================
// Register offsets within the device control memory window.
// ==========================================================================
`define UTWM_OFF_W1_CTRL 8'h14
`define UTWM_OFF_W1_BASE 8'h18
`define UTWM_OFF_W1_LIMIT 8'h1C
`define UTWM_OFF_W2_CTRL 8'h20
`define UTWM_OFF_W2_BASE 8'h24
`define UTWM_OFF_W2_LIMIT 8'h28

// ==========================================================================
// Control register fields and reset values.
// ==========================================================================
`define UTWM_CTRL_ACTIVE_BIT 0
`define UTWM_CTRL_TC_LSB 1
`define UTWM_CTRL_TC_MSB 3
`define UTWM_CTRL_WIDTH 16
`define UTWM_CTRL_RESET 16'h0000
`define UTWM_ADDR_RESET 32'h00000000
`define UTWM_TC_ZERO 3'h0

`endif

// ### utwm_master.sv
`timescale 1ns/1ps
module utwm_master (
  input wire clk,
  output reg up_valid = 1'b0,
  output reg up_is_mem = 1'b0,
  output reg [31:0] up_addr = 32'h0
);
  task issue(input [31:0] a, input m);
    @(posedge clk);
    up_valid <= 1'b1;
    up_is_mem <= m;
    up_addr <= a;
    @(posedge clk);
    up_valid <= 1'b0;
    up_addr <= ~a;
  endtask
endmodule

// ### utwm_window_map.v
`timescale 1ns/1ps
`include "utwm_defines.vh"

// How it works
// - Control register bits 15:4 read zero; writes to them are dropped.
// - Control bits 3:1 hold a read/write traffic class select, reset zero.
// - A window with its active bit clear never affects classification.
// - Active window: memory transactions inside its range get its traffic class unless a lower numbered window also matches.
// - Each window has a full 32-bit read/write base register.
// - Each window has a full 32-bit read/write limit register.
// - Base and limit store writes even while their window is disabled.
// - Control registers read all zeros after reset.
// - Non-zero classes only while the global upstream permit is set.
module utwm_window_map #(
  parameter NUM_WIN = 2
) (
  input wire clk,
  input wire rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  output wire [31:0] reg_rdata,
  input wire global_upstream_class_permit,
  input wire up_valid,
  input wire up_is_mem,
  input wire [31:0] up_addr,
  output wire up_tc_valid,
  output wire [2:0] up_tc,
  output wire up_hit
);

  // ==========================================================================
  // Reset images, field views and chains shared by all windows.
  // ==========================================================================
  localparam [`UTWM_CTRL_WIDTH-1:0] CTRL_RESET = `UTWM_CTRL_RESET;
  localparam ACTIVE_RESET = CTRL_RESET[`UTWM_CTRL_ACTIVE_BIT];
  localparam [2:0] TC_RESET = CTRL_RESET[`UTWM_CTRL_TC_MSB:`UTWM_CTRL_TC_LSB];

  // Only bits 3:0 of a control write have storage; the reserved bits are dropped.
  wire wdata_active = reg_wdata[`UTWM_CTRL_ACTIVE_BIT];
  wire [2:0] wdata_tc = reg_wdata[`UTWM_CTRL_TC_MSB:`UTWM_CTRL_TC_LSB];

  wire [32*(NUM_WIN+1)-1:0] rd_chain;
  wire [NUM_WIN:0] claim_chain;
  wire [3*(NUM_WIN+1)-1:0] tc_chain;

  // Each window ORs its read word into the chain and claims a hit only if no lower window did.
  assign rd_chain[31:0] = 32'h00000000;
  assign claim_chain[0] = 1'b0;
  assign tc_chain[2:0] = `UTWM_TC_ZERO;

  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g = g + 1) begin : g_win
      // Window registers repeat with a fixed stride from the first window's offsets.
      localparam [31:0] CTRL_OFF = `UTWM_OFF_W1_CTRL + (`UTWM_OFF_W2_CTRL - `UTWM_OFF_W1_CTRL) * g;
      localparam [31:0] BASE_OFF = `UTWM_OFF_W1_BASE + (`UTWM_OFF_W2_BASE - `UTWM_OFF_W1_BASE) * g;
      localparam [31:0] LIMIT_OFF = `UTWM_OFF_W1_LIMIT + (`UTWM_OFF_W2_LIMIT - `UTWM_OFF_W1_LIMIT) * g;

      wire [7:0] ctrl_off = CTRL_OFF[7:0];
      wire [7:0] base_off = BASE_OFF[7:0];
      wire [7:0] limit_off = LIMIT_OFF[7:0];

      wire sel_ctrl;
      wire sel_base;
      wire sel_limit;
      wire wr_ctrl;
      wire wr_base;
      wire wr_limit;

      reg window_active_q;
      reg window_active_d;
      reg [2:0] traffic_class_select_q;
      reg [2:0] traffic_class_select_d;
      reg [31:0] base_q;
      reg [31:0] base_d;
      reg [31:0] limit_q;
      reg [31:0] limit_d;

      wire [31:0] ctrl_word;
      reg [31:0] rd_word;
      wire above_base;
      wire below_limit;
      wire win_match;
      reg claim_here;
      reg [2:0] tc_here;

      // ======================================================================
      // Offset decode for this window.
      // ======================================================================
      assign sel_ctrl = (reg_addr == ctrl_off);
      assign sel_base = (reg_addr == base_off);
      assign sel_limit = (reg_addr == limit_off);
      assign wr_ctrl = reg_wr && sel_ctrl;
      assign wr_base = reg_wr && sel_base;
      assign wr_limit = reg_wr && sel_limit;

      // ======================================================================
      // Next register values.
      // ======================================================================
      always @* begin
        window_active_d = window_active_q;
        if (wr_ctrl) begin
          window_active_d = wdata_active;
        end
      end

      always @* begin
        traffic_class_select_d = traffic_class_select_q;
        if (wr_ctrl) begin
          traffic_class_select_d = wdata_tc;
        end
      end

      // Base and limit always accept writes; a disabled window just keeps them as scratch.
      always @* begin
        base_d = base_q;
        if (wr_base) begin
          base_d = reg_wdata;
        end
      end

      always @* begin
        limit_d = limit_q;
        if (wr_limit) begin
          limit_d = reg_wdata;
        end
      end

      // ======================================================================
      // Register flops.
      // ======================================================================
      // Every register returns to its reset image, so each window starts disabled.
      always @(posedge clk) begin
        if (rst) begin
          window_active_q <= ACTIVE_RESET;
        end else begin
          window_active_q <= window_active_d;
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          traffic_class_select_q <= TC_RESET;
        end else begin
          traffic_class_select_q <= traffic_class_select_d;
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          base_q <= `UTWM_ADDR_RESET;
        end else begin
          base_q <= base_d;
        end
      end

      always @(posedge clk) begin
        if (rst) begin
          limit_q <= `UTWM_ADDR_RESET;
        end else begin
          limit_q <= limit_d;
        end
      end

      // ======================================================================
      // Read word for this window.
      // ======================================================================
      assign ctrl_word = {28'h0000000, traffic_class_select_q, window_active_q};
      // The offset decodes are one-hot, so at most one branch applies.
      always @* begin
        rd_word = 32'h00000000;
        if (sel_ctrl) begin
          rd_word = ctrl_word;
        end
        if (sel_base) begin
          rd_word = base_q;
        end
        if (sel_limit) begin
          rd_word = limit_q;
        end
      end
      assign rd_chain[32*(g+1) +: 32] = rd_chain[32*g +: 32] | rd_word;

      // ======================================================================
      // Match and priority for this window.
      // ======================================================================
      assign above_base = (up_addr >= base_q);
      assign below_limit = (up_addr <= limit_q);
      // A disabled window never matches, so it cannot touch the class of any transaction.
      assign win_match = window_active_q && up_is_mem && above_base && below_limit;

      // A lower numbered window that already matched keeps its class.
      always @* begin
        claim_here = claim_chain[g];
        tc_here = tc_chain[3*g +: 3];
        if (win_match && !claim_chain[g]) begin
          claim_here = 1'b1;
          tc_here = traffic_class_select_q;
        end
      end
      assign claim_chain[g+1] = claim_here;
      assign tc_chain[3*(g+1) +: 3] = tc_here;
    end
  endgenerate

  // ==========================================================================
  // Register read port.
  // ==========================================================================
  reg [31:0] reg_rdata_q;
  reg [31:0] reg_rdata_d;

  // Unmapped offsets select no window and so read zero.
  // The read data holds between reads so software may sample it late.
  always @* begin
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      reg_rdata_d = rd_chain[32*NUM_WIN +: 32];
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      reg_rdata_q <= 32'h00000000;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // ==========================================================================
  // Classification, registered one cycle after the request.
  // ==========================================================================
  reg [2:0] mapped_tc;
  reg up_tc_valid_q;
  reg up_tc_valid_d;
  reg [2:0] up_tc_q;
  reg [2:0] up_tc_d;
  reg up_hit_q;
  reg up_hit_d;

  // The hit is still reported when the global permit forces class zero.
  always @* begin
    mapped_tc = tc_chain[3*NUM_WIN +: 3];
    if (!global_upstream_class_permit) begin
      mapped_tc = `UTWM_TC_ZERO;
    end
  end

  // A request sees the window state in force before a write on the same edge.
  always @* begin
    up_tc_valid_d = up_valid;
  end

  always @* begin
    up_tc_d = up_tc_q;
    if (up_valid) begin
      up_tc_d = mapped_tc;
    end
  end

  always @* begin
    up_hit_d = up_hit_q;
    if (up_valid) begin
      up_hit_d = claim_chain[NUM_WIN];
    end
  end

  // The class and hit hold until the next request.
  always @(posedge clk) begin
    if (rst) begin
      up_tc_valid_q <= 1'b0;
    end else begin
      up_tc_valid_q <= up_tc_valid_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      up_tc_q <= `UTWM_TC_ZERO;
    end else begin
      up_tc_q <= up_tc_d;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      up_hit_q <= 1'b0;
    end else begin
      up_hit_q <= up_hit_d;
    end
  end

  // ==========================================================================
  // Output ports.
  // ==========================================================================
  assign reg_rdata = reg_rdata_q;
  assign up_tc_valid = up_tc_valid_q;
  assign up_tc = up_tc_q;
  assign up_hit = up_hit_q;

endmodule
